// [hdl/glb_pkg.sv]
// constants for the global control register bank
// How it works
// RULE1: line standard bit picks T1 or E1
// RULE2: standard change reloads all framer defaults
// RULE3: reload completes within 34 line-clock cycles
// RULE4: host waits one frame after standard change
// RULE5: bit 14 selects backplane or GCI timing (code gives GCI only while bit 4 is clear)
// RULE6: bit 4 selects system clock rate
// RULE7: soft reset rising edge resets framers
// RULE8: soft reset equals hardware reset pin (code keeps mode bit 0 set through soft reset)
// RULE9: decode 9xx: A11,A8 high, A10,A9 low
// RULE10: channel field picks single-update channel
// RULE11: stream field picks capture source stream
// RULE12: capture updates only while enabled
// RULE13: host disables capture before reading buffer
// RULE14: framer field picks captured framer
// RULE15: whole-frame bit writes every channel
// RULE16: continuous bit repeats, else fill once
// RULE17: host should use continuous capture mode
// RULE18: framer 3 mask bits force status zero
// RULE19: unused bits read zero, writes ignored
package glb_pkg;
   localparam logic [11:0] ADDR_MODE = 12'h900;
   localparam logic [11:0] ADDR_CAPT = 12'h901;
   localparam logic [11:0] ADDR_MASK = 12'h902;
   localparam logic [15:0] MODE_WMASK = 16'hc011;
   localparam logic [15:0] CAPT_WMASK = 16'hf8ff;
   localparam logic [15:0] MASK_WMASK = 16'he000;
   localparam int MODE_STD_BIT = 15;
   localparam int MODE_TIM_BIT = 14;
   localparam int MODE_CLK_BIT = 4;
   localparam int MODE_RST_BIT = 0;
   localparam logic [15:0] MODE_RESET = 16'h8000;
   localparam logic [15:0] CAPT_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam int CAPT_CH_HI = 15;
   localparam int CAPT_CH_LO = 11;
   localparam int CAPT_STR_HI = 7;
   localparam int CAPT_STR_LO = 6;
   localparam int CAPT_EN_BIT = 5;
   localparam int CAPT_FR_HI = 4;
   localparam int CAPT_FR_LO = 2;
   localparam int CAPT_WHOLE_BIT = 1;
   localparam int CAPT_CONT_BIT = 0;
   localparam int MASK_HDLC_BIT = 15;
   localparam int MASK_ELAS_BIT = 14;
   localparam int MASK_RXL_BIT = 13;
   localparam int CLK_HZ = 200_000_000;
   localparam int RELOAD_LINE_CYC = 34;
   localparam int LINE_HZ = 1_544_000;
   // longest time rounds down
   localparam int RELOAD_CYC = (RELOAD_LINE_CYC * (CLK_HZ / 1000)) / (LINE_HZ / 1000);
   localparam int NUM_CHAN = 32;
   localparam int NUM_FRAMERS = 8;
   typedef enum logic [1:0] {
      STR_DATA_IN = 2'b00,
      STR_DATA_OUT = 2'b01,
      STR_SIG_IN = 2'b10,
      STR_SIG_OUT = 2'b11
   } stream_t;
   typedef enum logic [1:0] {
      CAP_IDLE = 2'b00,
      CAP_RUN = 2'b01,
      CAP_FULL = 2'b10
   } cap_state_t;
endpackage : glb_pkg

// [hdl/glb_regs.sv]
// global control registers, capture selection and framer 3 masks
`timescale 1ns/100ps
module glb_regs
   import glb_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // parallel host bus, from pins
   input wire logic CS_N_I,
   input wire logic WR_N_I,
   input wire logic RD_N_I,
   input wire logic [11:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   output logic [15:0] RDATA_O,
   output logic RDATA_OE_O,
   // mode outputs to framers
   output logic T1_MODE_O,
   output logic GCI_TIMING_O,
   output logic CLK_16M_O,
   output logic FRAMER_RESET_O,
   output logic DEFAULTS_T1_O,
   output logic RELOAD_BUSY_O,
   // capture engine
   input wire logic FRAME_START_I,
   input wire logic CHAN_STROBE_I,
   input wire logic [4:0] CHAN_NUM_I,
   input wire logic [7:0] DATA_IN_I,
   input wire logic [7:0] DATA_OUT_I,
   input wire logic [7:0] SIG_IN_I,
   input wire logic [7:0] SIG_OUT_I,
   output logic [2:0] CAPT_FRAMER_O,
   output logic CAPT_WE_O,
   output logic [4:0] CAPT_ADDR_O,
   output logic [7:0] CAPT_DATA_O,
   output logic CAPT_FULL_O,
   // framer 3 vector status
   input wire logic [2:0] F3_STATUS_I,
   output logic [2:0] F3_STATUS_O
);
   // pin synchronisers
   logic [1:0] cs_s, wr_s, rd_s;
   logic [11:0] addr_s1, addr_s2;
   logic [15:0] wd_s1, wd_s2;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_s <= 2'b11;
         wr_s <= 2'b11;
         rd_s <= 2'b11;
         addr_s1 <= '0;
         addr_s2 <= '0;
         wd_s1 <= '0;
         wd_s2 <= '0;
      end else begin
         cs_s <= {cs_s[0], CS_N_I};
         wr_s <= {wr_s[0], WR_N_I};
         rd_s <= {rd_s[0], RD_N_I};
         addr_s1 <= ADDR_I;
         addr_s2 <= addr_s1;
         wd_s1 <= WDATA_I;
         wd_s2 <= wd_s1;
      end
   end

   // one write per strobe: act on the cycle after falling edge
   logic wr_prev_r;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wr_prev_r <= 1'b0;
      end else begin
         wr_prev_r <= ~cs_s[1] & ~wr_s[1];
      end
   end
   logic wr_lvl, wr_pulse, glb_hit, rd_lvl;
   assign wr_lvl = ~cs_s[1] & ~wr_s[1];
   assign wr_pulse = wr_lvl & ~wr_prev_r;
   assign rd_lvl = ~cs_s[1] & ~rd_s[1];
   // RULE9
   assign glb_hit = addr_s2[11] & addr_s2[8] & ~addr_s2[10] & ~addr_s2[9];

   // soft reset acts as the pin: whole bank goes back to reset, except mode bit 0 which stays set
   logic soft_rst_r, mode_rst_prev_r;
   logic [15:0] mode_r, capt_r, mask_r;
   logic soft_rise;
   assign soft_rise = mode_r[MODE_RST_BIT] & ~mode_rst_prev_r; // RULE7

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         soft_rst_r <= 1'b0;
         mode_rst_prev_r <= 1'b0;
      end else begin
         soft_rst_r <= soft_rise; // RULE8
         mode_rst_prev_r <= mode_r[MODE_RST_BIT];
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mode_r <= MODE_RESET;
      end else if (soft_rst_r) begin
         // keep the soft reset bit so no second edge is seen
         mode_r <= MODE_RESET | (mode_r & 16'h0001); // RULE8
      end else if (wr_pulse && glb_hit && addr_s2 == ADDR_MODE) begin
         mode_r <= wd_s2 & MODE_WMASK; // RULE19
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         capt_r <= CAPT_RESET;
      end else if (soft_rst_r) begin
         capt_r <= CAPT_RESET; // RULE8
      end else if (wr_pulse && glb_hit && addr_s2 == ADDR_CAPT) begin
         capt_r <= wd_s2 & CAPT_WMASK; // RULE19
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_r <= MASK_RESET;
      end else if (soft_rst_r) begin
         mask_r <= MASK_RESET; // RULE8
      end else if (wr_pulse && glb_hit && addr_s2 == ADDR_MASK) begin
         mask_r <= wd_s2 & MASK_WMASK; // RULE19
      end
   end

   // read path
   logic [15:0] rd_nxt;
   always_comb begin
      rd_nxt = 16'h0000;
      if (glb_hit) begin
         case (addr_s2)
            ADDR_MODE: rd_nxt = mode_r;
            ADDR_CAPT: rd_nxt = capt_r;
            ADDR_MASK: rd_nxt = mask_r;
            default: rd_nxt = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= '0;
         RDATA_OE_O <= 1'b0;
      end else begin
         RDATA_O <= rd_nxt;
         RDATA_OE_O <= rd_lvl & glb_hit;
      end
   end

   // line standard change triggers default reload
   logic std_prev_r, std_change;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         std_prev_r <= 1'b1;
      end else begin
         std_prev_r <= mode_r[MODE_STD_BIT];
      end
   end
   assign std_change = mode_r[MODE_STD_BIT] ^ std_prev_r; // RULE2

   glb_reload u_reload (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .start_i(std_change | soft_rst_r),
      .busy_o(RELOAD_BUSY_O)
   );

   assign T1_MODE_O = mode_r[MODE_STD_BIT]; // RULE1
   // gci only meaningful at 2.048 Mb/s
   assign GCI_TIMING_O = mode_r[MODE_TIM_BIT] & ~mode_r[MODE_CLK_BIT]; // RULE5
   assign CLK_16M_O = mode_r[MODE_CLK_BIT]; // RULE6
   assign FRAMER_RESET_O = RELOAD_BUSY_O; // RULE2
   assign DEFAULTS_T1_O = mode_r[MODE_STD_BIT]; // RULE2

   // capture engine
   logic cap_en, whole, cont;
   logic [4:0] sel_ch;
   stream_t sel_str;
   assign cap_en = capt_r[CAPT_EN_BIT];
   assign whole = capt_r[CAPT_WHOLE_BIT];
   assign cont = capt_r[CAPT_CONT_BIT];
   assign sel_ch = capt_r[CAPT_CH_HI:CAPT_CH_LO];
   assign sel_str = stream_t'(capt_r[CAPT_STR_HI:CAPT_STR_LO]);
   assign CAPT_FRAMER_O = capt_r[CAPT_FR_HI:CAPT_FR_LO]; // RULE14

   logic [7:0] src;
   always_comb begin
      case (sel_str) // RULE11
         STR_DATA_IN: src = DATA_IN_I;
         STR_DATA_OUT: src = DATA_OUT_I;
         STR_SIG_IN: src = SIG_IN_I;
         STR_SIG_OUT: src = SIG_OUT_I;
         default: src = DATA_IN_I;
      endcase
   end

   cap_state_t cap_r;
   logic [4:0] fill_r;
   logic take;
   // RULE10 RULE15
   assign take = CHAN_STROBE_I && (whole || CHAN_NUM_I == sel_ch);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cap_r <= CAP_IDLE;
         fill_r <= '0;
      end else if (soft_rst_r || !cap_en) begin
         cap_r <= CAP_IDLE;
         fill_r <= '0;
      end else begin
         case (cap_r)
            CAP_IDLE: if (FRAME_START_I) cap_r <= CAP_RUN;
            CAP_RUN: if (take) begin
               fill_r <= fill_r + 5'd1;
               if (fill_r == 5'd31 && !cont) cap_r <= CAP_FULL; // RULE16
            end
            CAP_FULL: cap_r <= CAP_FULL;
            default: cap_r <= CAP_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CAPT_WE_O <= 1'b0;
         CAPT_ADDR_O <= '0;
         CAPT_DATA_O <= '0;
      end else begin
         CAPT_WE_O <= cap_en && cap_r == CAP_RUN && take; // RULE12
         CAPT_ADDR_O <= whole ? CHAN_NUM_I : fill_r;
         CAPT_DATA_O <= src;
      end
   end
   assign CAPT_FULL_O = (cap_r == CAP_FULL);

   // framer 3 status gating
   assign F3_STATUS_O[2] = F3_STATUS_I[2] & ~mask_r[MASK_HDLC_BIT]; // RULE18
   assign F3_STATUS_O[1] = F3_STATUS_I[1] & ~mask_r[MASK_ELAS_BIT]; // RULE18
   assign F3_STATUS_O[0] = F3_STATUS_I[0] & ~mask_r[MASK_RXL_BIT]; // RULE18

   std_reload_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      std_change |=> RELOAD_BUSY_O) else $error("no reload on change"); // RULE2
   soft_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      soft_rise |=> ##1 mode_r[MODE_STD_BIT] && capt_r == 16'h0) else $error("soft reset"); // RULE7
   capt_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      !cap_en |=> !CAPT_WE_O) else $error("capture while disabled"); // RULE12
   mask_gate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      mask_r[MASK_HDLC_BIT] |-> !F3_STATUS_O[2]) else $error("mask leak"); // RULE18
   unused_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      (mode_r & ~MODE_WMASK) == 16'h0) else $error("unused bit set"); // RULE19
   gci_rate_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      CLK_16M_O |-> !GCI_TIMING_O) else $error("gci at high rate"); // RULE5
   std_out_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      $changed(T1_MODE_O) |=> FRAMER_RESET_O && DEFAULTS_T1_O == T1_MODE_O)
      else $error("mode change without reload"); // RULE1
   single_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
      CAPT_FULL_O && cap_en && !soft_rst_r |=> CAPT_FULL_O) else $error("full left"); // RULE16
   cov_std_c: cover property (@(posedge CLK_I) std_change);
   cov_full_c: cover property (@(posedge CLK_I) CAPT_FULL_O);
   cov_we_c: cover property (@(posedge CLK_I) CAPT_WE_O);
endmodule : glb_regs

// [hdl/glb_reload.sv]
// default reload sequencer: a trigger starts the busy window, or restarts it while busy
`timescale 1ns/100ps
module glb_reload
   import glb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   output logic busy_o
);
   localparam int CW = $clog2(RELOAD_CYC + 1);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (start_i) begin
         cnt_r <= CW'(RELOAD_CYC); // RULE3
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign busy_o = (cnt_r != '0);

   reload_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      start_i |=> busy_o [*8]) else $error("reload window too short"); // RULE3
endmodule : glb_reload

// [sim/host_model.sv]
// host processor model on the parallel register pins
`timescale 1ns/100ps
module host_model #(
   parameter int FRAME_CYC = 25000
) (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   output logic cs_n_o,
   output logic wr_n_o,
   output logic rd_n_o,
   output logic [11:0] addr_o,
   output logic [15:0] wdata_o
);
   logic std_r = 1'b1;
   initial begin
      {cs_n_o, wr_n_o, rd_n_o} = 3'b111;
      addr_o = 12'h000;
      wdata_o = 16'h0000;
   end
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      {cs_n_o, wr_n_o} <= 2'b00;
      repeat (4) @(posedge clk_i);
      {cs_n_o, wr_n_o} <= 2'b11;
      // released bus does not keep the last word
      wdata_o <= ~d;
      repeat (4) @(posedge clk_i);
      if (a == 12'h900 && (d[15] !== std_r || d[0])) begin
         std_r = d[0] ? 1'b1 : d[15];
         repeat (FRAME_CYC) @(posedge clk_i);
      end
   endtask : wr
   task rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      {cs_n_o, rd_n_o} <= 2'b00;
      repeat (5) @(posedge clk_i);
      d = rdata_i;
      {cs_n_o, rd_n_o} <= 2'b11;
      repeat (4) @(posedge clk_i);
   endtask : rd
endmodule : host_model

// [sim/tb_top.sv]
// bench for the global control register bank
`timescale 1ns/100ps
module tb_top
   import glb_pkg::*;
;
   logic CLK_I = 1'b0, RST_I = 1'b1, FRAME_START_I = 1'b0, CHAN_STROBE_I = 1'b0;
   logic CS_N_I, WR_N_I, RD_N_I, RDATA_OE_O, T1_MODE_O, GCI_TIMING_O, CLK_16M_O;
   logic FRAMER_RESET_O, DEFAULTS_T1_O, RELOAD_BUSY_O, CAPT_WE_O, CAPT_FULL_O;
   logic [11:0] ADDR_I;
   logic [15:0] WDATA_I, RDATA_O, rv;
   logic [4:0] CHAN_NUM_I = 5'h00, CAPT_ADDR_O;
   logic [7:0] DATA_IN_I = 8'h00, DATA_OUT_I = 8'h00, SIG_IN_I = 8'h00, SIG_OUT_I = 8'h00;
   logic [7:0] CAPT_DATA_O, rnd = 8'h1f;
   logic [2:0] CAPT_FRAMER_O, F3_STATUS_I = 3'h7, F3_STATUS_O;
   logic [12:0] expq[$], seenq[$];
   logic [4:0] chan_sel;
   int failures = 0, comparisons = 0, cyc = 0, busy_cnt = 0, nfill = 0;
   int oe_cnt = 0, frst_cnt = 0, slot = 0;
   glb_regs i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .WR_N_I(WR_N_I),
      .RD_N_I(RD_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
      .RDATA_OE_O(RDATA_OE_O), .T1_MODE_O(T1_MODE_O), .GCI_TIMING_O(GCI_TIMING_O),
      .CLK_16M_O(CLK_16M_O), .FRAMER_RESET_O(FRAMER_RESET_O),
      .DEFAULTS_T1_O(DEFAULTS_T1_O), .RELOAD_BUSY_O(RELOAD_BUSY_O),
      .FRAME_START_I(FRAME_START_I), .CHAN_STROBE_I(CHAN_STROBE_I), .CHAN_NUM_I(CHAN_NUM_I),
      .DATA_IN_I(DATA_IN_I), .DATA_OUT_I(DATA_OUT_I), .SIG_IN_I(SIG_IN_I),
      .SIG_OUT_I(SIG_OUT_I), .CAPT_FRAMER_O(CAPT_FRAMER_O), .CAPT_WE_O(CAPT_WE_O),
      .CAPT_ADDR_O(CAPT_ADDR_O), .CAPT_DATA_O(CAPT_DATA_O), .CAPT_FULL_O(CAPT_FULL_O),
      .F3_STATUS_I(F3_STATUS_I), .F3_STATUS_O(F3_STATUS_O));
   host_model i_host (.clk_i(CLK_I), .rdata_i(RDATA_O), .cs_n_o(CS_N_I), .wr_n_o(WR_N_I),
      .rd_n_o(RD_N_I), .addr_o(ADDR_I), .wdata_o(WDATA_I));
   initial begin
      forever #2.5 CLK_I = ~CLK_I;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task final_report;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk
   always @(posedge CLK_I) begin
      if (CAPT_WE_O === 1'b1) seenq.push_back({CAPT_ADDR_O, CAPT_DATA_O});
      if (RELOAD_BUSY_O === 1'b1) busy_cnt++;
      if (FRAMER_RESET_O === 1'b1) frst_cnt++;
      if (RDATA_OE_O === 1'b1) oe_cnt++;
      cyc++;
      // two frame waits dominate the run
      if (cyc == 80000) begin
         failures++;
         final_report();
      end
   end
   // bench model: one frame of strobes, expected capture words queued
   task frame(input int sel, input int strm, input bit whole, input bit en, input bit cont);
      logic [7:0] v[4];
      FRAME_START_I <= 1'b1;
      @(posedge CLK_I);
      FRAME_START_I <= 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         rnd = lfsr(rnd);
         v = '{rnd, ~rnd, rnd ^ 8'h5a, rnd ^ 8'ha5};
         {DATA_IN_I, DATA_OUT_I, SIG_IN_I, SIG_OUT_I} <= {v[0], v[1], v[2], v[3]};
         {CHAN_STROBE_I, CHAN_NUM_I} <= {1'b1, c[4:0]};
         if (en && (whole || c == sel) && (cont || nfill < NUM_CHAN)) begin
            // whole frame lands by channel, single channel by fill position
            expq.push_back({whole ? 5'(c) : 5'(slot), v[strm]});
            nfill++;
            slot++;
         end
         @(posedge CLK_I);
         CHAN_STROBE_I <= 1'b0;
         @(posedge CLK_I);
      end
      repeat (8) @(posedge CLK_I);
   endtask : frame
   task cmp_cap;
      chk(16'(seenq.size()), 16'(expq.size()), "capture count");
      foreach (expq[i]) if (i < seenq.size()) chk({3'h0, seenq[i]}, {3'h0, expq[i]}, "cap");
      expq.delete();
      seenq.delete();
      nfill = 0;
   endtask : cmp_cap
   initial begin
      repeat (5) @(posedge CLK_I);
      RST_I <= 1'b0;
      repeat (4) @(posedge CLK_I);
      i_host.rd(ADDR_MODE, rv);
      chk(rv, MODE_RESET, "mode reset");
      // strobe held five cycles, enable stands as long
      chk(16'(oe_cnt), 16'd5, "read enable");
      chk({15'h0, T1_MODE_O}, 16'h1, "t1 at reset");
      i_host.wr(ADDR_MODE, 16'hfffe);
      i_host.rd(ADDR_MODE, rv);
      chk(rv, 16'hc010, "unused bits");
      chk({14'h0, GCI_TIMING_O, CLK_16M_O}, 16'h1, "gci needs slow rate");
      i_host.wr(12'ha00, 16'h0000);
      i_host.rd(ADDR_MODE, rv);
      chk(rv, 16'hc010, "outside 9xx");
      oe_cnt = 0;
      i_host.rd(12'ha00, rv);
      chk(rv, 16'h0000, "read outside 9xx");
      chk(16'(oe_cnt), 16'h0, "no enable outside 9xx");
      busy_cnt = 0;
      frst_cnt = 0;
      i_host.wr(ADDR_MODE, 16'h4000);
      chk({13'h0, T1_MODE_O, DEFAULTS_T1_O, GCI_TIMING_O}, 16'h1, "e1 reload");
      chk(16'(busy_cnt > 0 && busy_cnt <= RELOAD_CYC), 16'h1, "reload length");
      chk(16'(frst_cnt > 0 && frst_cnt <= RELOAD_CYC), 16'h1, "framer reset");
      i_host.wr(ADDR_MASK, MASK_WMASK);
      chk({13'h0, F3_STATUS_O}, 16'h0, "masked");
      i_host.wr(ADDR_MASK, 16'h0000);
      chk({13'h0, F3_STATUS_O}, 16'h7, "unmasked");
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr(rnd);
         // frame advances the lfsr, so the channel is kept aside
         chan_sel = rnd[4:0];
         i_host.wr(ADDR_CAPT, {chan_sel, 3'h0, 2'(s), 1'b1, 3'(s + 1), 2'b01});
         chk({13'h0, CAPT_FRAMER_O}, 16'(s + 1), "framer sel");
         repeat (2) frame(int'(chan_sel), s, 0, 1, 1);
         cmp_cap();
      end
      // disable first so single mode starts a fresh fill
      i_host.wr(ADDR_CAPT, 16'h0000);
      slot = 0;
      i_host.wr(ADDR_CAPT, {8'h00, 2'd1, 1'b1, 3'd7, 2'b10});
      repeat (2) frame(0, 1, 1, 1, 0);
      cmp_cap();
      chk({15'h0, CAPT_FULL_O}, 16'h1, "single full");
      i_host.wr(ADDR_CAPT, 16'h0001);
      frame(0, 0, 1, 0, 1);
      cmp_cap();
      chk({15'h0, CAPT_FULL_O}, 16'h0, "full cleared");
      frst_cnt = 0;
      i_host.wr(ADDR_MODE, 16'h0001);
      i_host.rd(ADDR_MODE, rv);
      chk(rv, MODE_RESET | 16'h1, "soft reset mode");
      i_host.rd(ADDR_CAPT, rv);
      chk(rv, CAPT_RESET, "soft reset capt");
      chk({15'h0, DEFAULTS_T1_O}, 16'h1, "t1 defaults");
      chk(16'(frst_cnt > 0), 16'h1, "soft reset reloads");
      final_report();
   end
endmodule : tb_top
